// ==== rtl/hub_cfg_pkg.sv ====
package hub_cfg_pkg;
   localparam int NUM_PORTS = 7;
   localparam int ROM_BYTES = 32;
   localparam logic [7:0] CHECK0_VAL = 8'h40;
   localparam logic [7:0] CHECK1_VAL = 8'h1a;
   localparam int ADDR_CHECK0 = 'h00;
   localparam int ADDR_CHECK1 = 'h01;
   localparam int ADDR_VID = 'h02;
   localparam int ADDR_PID = 'h04;
   localparam int ADDR_REL = 'h06;
   localparam int ADDR_SERIAL = 'h08;
   localparam int SERIAL_MAX = 16;
   localparam int ADDR_SER_LEN = 'h18;
   localparam int ADDR_PORTS = 'h1a;
   localparam int ADDR_REMOVE = 'h1c;
   localparam int ADDR_ATTR = 'h1e;
   localparam int ADDR_CSUM = 'h1f;
   localparam logic [6:0] ROM_DEV_ADDR = 7'h50;
   localparam int CLK_HZ = 50_000_000;
   localparam int SCL_HZ = 100_000;
   // Quarter period of the bus clock, rounded up so the bus never runs faster than intended.
   localparam int QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
   localparam logic [15:0] DEF_VID = 16'h1234;   // Arbitrary value.
   localparam logic [15:0] DEF_PID = 16'h5678;   // Arbitrary value.
   localparam logic [15:0] DEF_REL = 16'h0100;
   localparam int TT_COUNT = NUM_PORTS;
endpackage

// ==== rtl/hub_config_and_port_power.sv ====
`timescale 1ns/10ps
module hub_config_and_port_power #(
   parameter int NUM_PORTS = hub_cfg_pkg::NUM_PORTS,
   parameter int QTR_CYC = hub_cfg_pkg::QTR_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic external_reset_n,
   input wire logic [NUM_PORTS-1:0] port_overcurrent_n,
   input wire logic hubConfigured,
   input wire logic suspendReq,
   input wire logic [1:0] strapPortSel,
   input wire logic [2:0] strapRemoveSel,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic sclOut,
   output logic sclOe,
   output logic [NUM_PORTS-1:0] port_power_enable_n,
   output logic [NUM_PORTS-1:0] portPowerOe,
   output logic cfgReady,
   output logic romValid,
   output logic suspended,
   output logic [15:0] vendorId,
   output logic [15:0] productId,
   output logic [15:0] releaseBcd,
   output logic [3:0] portCount,
   output logic [7:0] removableMask,
   output logic [7:0] serialLen,
   output logic [7:0] deviceAttr,
   output logic selfPowered,
   output logic [NUM_PORTS-1:0] ttPresent
);
   // The port fields and the 8-bit tick counter bound what the logic can serve.
   if (NUM_PORTS < 4 || NUM_PORTS > 7) begin : g_bad_ports
      $error("NUM_PORTS must be 4 to 7.");
   end
   if (QTR_CYC < 1 || QTR_CYC > 256) begin : g_bad_qtr
      $error("QTR_CYC must be 1 to 256.");
   end

   // -----------------------------------------------------------------
   // Reset, straps and port power
   // -----------------------------------------------------------------
   logic rst;
   logic [1:0] strapPort_r, strapPort_nxt;
   logic [2:0] strapRem_r, strapRem_nxt;
   logic inReset_r, inReset_nxt;
   logic susp_r, susp_nxt;

   // Either reset source restarts the loader; the pin is taken as synchronous.
   assign rst = sys_rst | ~external_reset_n;

   // Straps are caught while reset is held, so they are stable at release.
   always_comb begin
      strapPort_nxt = strapPort_r;
      strapRem_nxt = strapRem_r;
      inReset_nxt = 1'b0;
      susp_nxt = suspendReq & cfgReady;
      if (rst) begin
         strapPort_nxt = strapPortSel;
         strapRem_nxt = strapRemoveSel;
         inReset_nxt = 1'b1;
         susp_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      strapPort_r <= strapPort_nxt;
      strapRem_r <= strapRem_nxt;
      inReset_r <= inReset_nxt;
      susp_r <= susp_nxt;
   end

   // Enable pulls low on overcurrent (low input) or while unconfigured.
   always_comb begin
      for (int i = 0; i < NUM_PORTS; i++) begin
         portPowerOe[i] = ~port_overcurrent_n[i] | ~hubConfigured;
         port_power_enable_n[i] = 1'b0;
      end
   end
   assign suspended = susp_r;
   assign selfPowered = 1'b1; // Always self powered; 500mA per port is a board budget.
   assign ttPresent = '1;     // One translator per port.

   // -----------------------------------------------------------------
   // EEPROM reader: random-address set, then sequential read of all bytes
   // -----------------------------------------------------------------
   typedef enum {S_IDLE, S_START, S_BIT, S_ACK, S_RDBIT, S_MACK, S_STOP, S_CHECK, S_DONE} rd_state_t;
   rd_state_t st_r, st_nxt;
   logic [7:0] rom_r [hub_cfg_pkg::ROM_BYTES];
   logic [7:0] shift_r, shift_nxt;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [1:0] phase_r, phase_nxt;
   logic [1:0] byteSel_r, byteSel_nxt; // 0 write-addr, 1 word addr, 2 read-addr.
   logic [4:0] idx_r, idx_nxt;
   logic [7:0] tick_r, tick_nxt;
   logic nack_r, nack_nxt;
   logic valid_r, valid_nxt;
   logic sda_r, sda_nxt, scl_r, scl_nxt;
   logic tick;
   logic wrByte;
   logic [7:0] csum;

   assign tick = (tick_r == 8'(QTR_CYC - 1));

   // XOR checksum of all bytes below the checksum location.
   always_comb begin
      csum = 8'h00;
      for (int i = 0; i < hub_cfg_pkg::ADDR_CSUM; i++) csum = csum ^ rom_r[i];
   end

   // Four phases per bit: low/set data, rise, high, fall.
   always_comb begin
      st_nxt = st_r;
      shift_nxt = shift_r;
      bitCnt_nxt = bitCnt_r;
      phase_nxt = phase_r;
      byteSel_nxt = byteSel_r;
      idx_nxt = idx_r;
      nack_nxt = nack_r;
      valid_nxt = valid_r;
      sda_nxt = sda_r;
      scl_nxt = scl_r;
      wrByte = 1'b0;
      tick_nxt = tick ? 8'h00 : tick_r + 8'h01;
      if (tick) begin
         phase_nxt = phase_r + 2'd1;
         case (st_r)
            S_IDLE: begin
               sda_nxt = 1'b1;
               scl_nxt = 1'b1;
               phase_nxt = 2'd0;
               st_nxt = S_START;
            end
            S_START: begin
               // Data goes high before the clock rises, so a repeated start is a real start too.
               if (phase_r == 2'd0) sda_nxt = 1'b1;
               if (phase_r == 2'd1) scl_nxt = 1'b1;
               if (phase_r == 2'd2) sda_nxt = 1'b0;
               if (phase_r == 2'd3) begin
                  scl_nxt = 1'b0;
                  st_nxt = S_BIT;
                  bitCnt_nxt = 3'd7;
                  shift_nxt = (byteSel_r == 2'd0) ? {hub_cfg_pkg::ROM_DEV_ADDR, 1'b0} :
                     (byteSel_r == 2'd1) ? 8'h00 : {hub_cfg_pkg::ROM_DEV_ADDR, 1'b1};
               end
            end
            S_BIT, S_ACK, S_RDBIT, S_MACK: begin
               if (phase_r == 2'd0) begin
                  sda_nxt = (st_r == S_BIT) ? shift_r[7] :
                     (st_r == S_MACK) ? (idx_r == 5'(hub_cfg_pkg::ROM_BYTES - 1)) : 1'b1;
               end
               if (phase_r == 2'd1) scl_nxt = 1'b1;
               if (phase_r == 2'd2) begin
                  if (st_r == S_RDBIT) shift_nxt = {shift_r[6:0], sdaIn};
                  if (st_r == S_ACK && sdaIn) nack_nxt = 1'b1;
               end
               if (phase_r == 2'd3) begin
                  scl_nxt = 1'b0;
                  case (st_r)
                     S_BIT: begin
                        shift_nxt = {shift_r[6:0], 1'b0};
                        bitCnt_nxt = bitCnt_r - 3'd1;
                        if (bitCnt_r == 3'd0) st_nxt = S_ACK;
                     end
                     S_ACK: begin
                        bitCnt_nxt = 3'd7;
                        if (nack_r) st_nxt = S_STOP;
                        else if (byteSel_r == 2'd0) begin
                           byteSel_nxt = 2'd1;
                           st_nxt = S_BIT;
                           shift_nxt = 8'h00; // Start at location zero.
                        end else if (byteSel_r == 2'd1) begin
                           byteSel_nxt = 2'd2;
                           st_nxt = S_START;
                           sda_nxt = 1'b1;
                        end else st_nxt = S_RDBIT;
                     end
                     S_RDBIT: begin
                        bitCnt_nxt = bitCnt_r - 3'd1;
                        if (bitCnt_r == 3'd0) begin
                           st_nxt = S_MACK;
                           wrByte = 1'b1;
                        end
                     end
                     default: begin
                        bitCnt_nxt = 3'd7;
                        idx_nxt = idx_r + 5'd1; // Sequential read.
                        st_nxt = (idx_r == 5'(hub_cfg_pkg::ROM_BYTES - 1)) ? S_STOP : S_RDBIT;
                     end
                  endcase
               end
            end
            S_STOP: begin
               if (phase_r == 2'd0) sda_nxt = 1'b0;
               if (phase_r == 2'd1) scl_nxt = 1'b1;
               if (phase_r == 2'd2) sda_nxt = 1'b1;
               if (phase_r == 2'd3) st_nxt = S_CHECK;
            end
            S_CHECK: begin
               // Check bytes and checksum both required.
               valid_nxt = !nack_r && rom_r[hub_cfg_pkg::ADDR_CHECK0] == hub_cfg_pkg::CHECK0_VAL
                  && rom_r[hub_cfg_pkg::ADDR_CHECK1] == hub_cfg_pkg::CHECK1_VAL
                  && rom_r[hub_cfg_pkg::ADDR_CSUM] == csum;
               st_nxt = S_DONE;
            end
            S_DONE: st_nxt = S_DONE;
            default: st_nxt = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst || inReset_r) begin
         st_r <= S_IDLE;
         shift_r <= 8'h00;
         bitCnt_r <= 3'd7;
         phase_r <= 2'd0;
         byteSel_r <= 2'd0;
         idx_r <= 5'd0;
         tick_r <= 8'h00;
         nack_r <= 1'b0;
         valid_r <= 1'b0;
         sda_r <= 1'b1;
         scl_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         shift_r <= shift_nxt;
         bitCnt_r <= bitCnt_nxt;
         phase_r <= phase_nxt;
         byteSel_r <= byteSel_nxt;
         idx_r <= idx_nxt;
         tick_r <= tick_nxt;
         nack_r <= nack_nxt;
         valid_r <= valid_nxt;
         sda_r <= sda_nxt;
         scl_r <= scl_nxt;
      end
   end

   // Byte store; one entry per EEPROM location. The eighth bit is already in the shifter.
   always_ff @(posedge clk) begin
      if (wrByte) rom_r[idx_r] <= shift_r;
   end

   // Open-drain bus: drive low only.
   assign sdaOut = 1'b0;
   assign sdaOe = ~sda_r;
   assign sclOut = 1'b0;
   assign sclOe = ~scl_r;

   // -----------------------------------------------------------------
   // Descriptor values, held until the next reset
   // -----------------------------------------------------------------
   logic [3:0] strapCount;
   logic [7:0] strapRemove;
   assign strapCount = 4'd4 + {2'b00, strapPort_r};
   assign strapRemove = (8'h01 << strapRem_r) - 8'h01;

   always_ff @(posedge clk) begin
      if (rst) begin
         cfgReady <= 1'b0;
         romValid <= 1'b0;
         vendorId <= hub_cfg_pkg::DEF_VID;
         productId <= hub_cfg_pkg::DEF_PID;
         releaseBcd <= hub_cfg_pkg::DEF_REL;
         portCount <= 4'(NUM_PORTS);
         removableMask <= 8'h00;
         serialLen <= 8'h00;
         deviceAttr <= 8'h00;
      end else if (st_r == S_DONE && !cfgReady) begin
         cfgReady <= 1'b1;
         romValid <= valid_r;
         if (valid_r) begin
            vendorId <= {rom_r[hub_cfg_pkg::ADDR_VID + 1], rom_r[hub_cfg_pkg::ADDR_VID]};
            productId <= {rom_r[hub_cfg_pkg::ADDR_PID + 1], rom_r[hub_cfg_pkg::ADDR_PID]};
            releaseBcd <= {rom_r[hub_cfg_pkg::ADDR_REL + 1], rom_r[hub_cfg_pkg::ADDR_REL]};
            portCount <= rom_r[hub_cfg_pkg::ADDR_PORTS][3:0];
            removableMask <= rom_r[hub_cfg_pkg::ADDR_REMOVE];
            // Serial always reported with EEPROM, clipped to 16 characters.
            serialLen <= (rom_r[hub_cfg_pkg::ADDR_SER_LEN] > 8'(hub_cfg_pkg::SERIAL_MAX)) ?
               8'(hub_cfg_pkg::SERIAL_MAX) : rom_r[hub_cfg_pkg::ADDR_SER_LEN];
            deviceAttr <= rom_r[hub_cfg_pkg::ADDR_ATTR];
         end else begin
            portCount <= strapCount;
            removableMask <= {strapRemove[6:0], 1'b0};
         end
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   chk_power_overcur: assert property (@(posedge clk)
      (portPowerOe & ~port_overcurrent_n) == ~port_overcurrent_n)
      else $error("Port power not asserted on overcurrent.");
   chk_power_unconf: assert property (@(posedge clk)
      !hubConfigured |-> &portPowerOe)
      else $error("Port power not asserted while unconfigured.");
   chk_invalid_default: assert property (@(posedge clk) disable iff (rst)
      $rose(cfgReady) && !romValid |-> vendorId == hub_cfg_pkg::DEF_VID && productId == hub_cfg_pkg::DEF_PID)
      else $error("Defaults not used for invalid EEPROM.");
   chk_valid_checks: assert property (@(posedge clk) disable iff (rst)
      $rose(romValid) |-> $past(rom_r[hub_cfg_pkg::ADDR_CHECK0]) == hub_cfg_pkg::CHECK0_VAL
         && $past(rom_r[hub_cfg_pkg::ADDR_CHECK1]) == hub_cfg_pkg::CHECK1_VAL
         && $past(csum) == $past(rom_r[hub_cfg_pkg::ADDR_CSUM]))
      else $error("EEPROM accepted with bad check values.");
   chk_nack_absent: assert property (@(posedge clk) disable iff (rst)
      nack_r |-> !valid_r)
      else $error("Absent EEPROM treated as valid.");
   chk_reset_clear: assert property (@(posedge clk)
      rst |=> !cfgReady && !romValid && !suspended)
      else $error("Reset did not clear status.");
   chk_suspend_cfg: assert property (@(posedge clk) disable iff (rst)
      suspended |-> $past(cfgReady))
      else $error("Suspend before configuration loaded.");
   chk_serial_max: assert property (@(posedge clk)
      serialLen <= 8'(hub_cfg_pkg::SERIAL_MAX))
      else $error("Serial length above limit.");
   cov_valid: cover property (@(posedge clk) $rose(romValid));
   cov_default: cover property (@(posedge clk) $rose(cfgReady) && !romValid);
   cov_overcur: cover property (@(posedge clk) hubConfigured && !port_overcurrent_n[0]);
endmodule // hub_config_and_port_power

// ==== sim/i2c_rom_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Serial configuration memory on the two-wire bus
// ----------------------------------------
module i2c_rom_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic present,
   output logic sdaPull
);
   logic [7:0] mem [0:31];
   logic [7:0] sh;
   logic [7:0] ob;
   logic [4:0] ptr;
   logic rd;
   int bits;
   int st;

   initial begin
      sdaPull = 1'b0;
      st = 0;
      bits = 0;
   end

   // Start and stop conditions. A start restarts byte framing.
   always @(negedge sda) if (scl === 1'b1) begin
      st = 1;
      bits = 0;
   end
   always @(posedge sda) if (scl === 1'b1) st = 0;

   // Sample on the rising clock; a master NACK ends the read.
   always @(posedge scl) if (st != 0 && st != 4) begin
      if (bits < 8) sh = {sh[6:0], sda};
      else if (st == 3 && sda) st = 0;
      bits++;
   end

   // Drive only while the clock is low, so no false start or stop is seen.
   // An absent part never pulls, and the pull-up leaves the line high.
   always @(negedge scl) if (st != 0 && st != 4) begin
      if (bits == 8) begin
         if (st == 1) begin
            if (present && sh[7:1] == 7'h50) begin
               sdaPull = 1'b1;
               rd = sh[0];
            end else st = 0;
         end else if (st == 2) begin
            ptr = sh[4:0];
            sdaPull = 1'b1;
         end else sdaPull = 1'b0;
      end else if (bits == 9) begin
         bits = 0;
         sdaPull = 1'b0;
         if (st == 1) st = rd ? 3 : 2;
         else if (st == 2) st = 4;
         // Sequential read from the pointer, one byte after another.
         if (st == 3) begin
            ob = mem[ptr];
            ptr++;
            sdaPull = ~ob[7];
         end
      end else if (st == 3) sdaPull = ~ob[7 - bits];
   end
endmodule // i2c_rom_model

// ==== sim/tb.sv ====
`timescale 1ns/10ps
module tb;
   localparam int CYC_LIMIT = 40000;
   logic clk, sys_rst, extRstN, hubConfigured, suspendReq, romPresent, sdaPull;
   logic [6:0] overcurrentN, portPowerOe, powerEnN, ttPresent;
   logic [1:0] strapPortSel;
   logic [2:0] strapRemoveSel;
   logic sdaOut, sdaOe, sclOut, sclOe, cfgReady, romValid, suspended, selfPowered;
   logic [15:0] vendorId, productId, releaseBcd;
   logic [3:0] portCount;
   logic [7:0] removableMask, serialLen, deviceAttr;
   wire sclLine = ~sclOe;
   wire sdaLine = ~(sdaOe | sdaPull);
   int bad_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed = 26;

   // A short bus-clock quarter keeps each load brief; the bus sequence itself is unchanged.
   hub_config_and_port_power #(.QTR_CYC(4)) dut (.clk(clk), .sys_rst(sys_rst), .external_reset_n(extRstN),
      .port_overcurrent_n(overcurrentN), .hubConfigured(hubConfigured), .suspendReq(suspendReq),
      .strapPortSel(strapPortSel), .strapRemoveSel(strapRemoveSel), .sdaIn(sdaLine), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe), .port_power_enable_n(powerEnN),
      .portPowerOe(portPowerOe), .cfgReady(cfgReady), .romValid(romValid), .suspended(suspended),
      .vendorId(vendorId), .productId(productId), .releaseBcd(releaseBcd), .portCount(portCount),
      .removableMask(removableMask), .serialLen(serialLen), .deviceAttr(deviceAttr),
      .selfPowered(selfPowered), .ttPresent(ttPresent));
   i2c_rom_model eep (.scl(sclLine), .sda(sdaLine), .present(romPresent), .sdaPull(sdaPull));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == CYC_LIMIT) begin
         bad_count++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Compare and report tasks
   // ----------------------------------------
   task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmpPwr(input logic [6:0] got, input logic [6:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Random overcurrent and configured levels; the enables follow at once.
   task automatic powerAndSuspend();
      for (int i = 0; i < 24; i++) begin
         @(negedge clk);
         overcurrentN = 7'($random(seed));
         hubConfigured = 1'($random(seed));
         #1;
         cmpPwr(portPowerOe, ~overcurrentN | {7{~hubConfigured}});
         cmpPwr(powerEnN, 7'h00);
      end
      cmpPwr(ttPresent, 7'h7f);
      cmpVal(16'(selfPowered), 16'h0001);
      cmpVal(16'({sdaOut, sclOut}), 16'h0000);
      @(negedge clk);
      suspendReq = 1'b1;
      @(negedge clk);
      cmpVal(16'(suspended), 16'h0001);
      suspendReq = 1'b0;
      @(negedge clk);
      cmpVal(16'(suspended), 16'h0000);
   endtask

   // Mode 0 good contents, 1 bad check byte, 2 bad checksum, 3 no part.
   task automatic runLoad(input bit useExt, input int mode);
      logic [7:0] x;
      logic [1:0] ps;
      logic [2:0] rs;
      bit ok;
      int n;
      for (int i = 0; i < 32; i++) eep.mem[i] = 8'($random(seed));
      eep.mem[0] = hub_cfg_pkg::CHECK0_VAL;
      eep.mem[1] = (mode == 1) ? 8'h1b : hub_cfg_pkg::CHECK1_VAL;
      eep.mem[26] = 8'h04 + 8'($random(seed) & 3);
      x = 8'h00;
      for (int i = 0; i < 31; i++) x ^= eep.mem[i];
      eep.mem[31] = (mode == 2) ? ~x : x;
      romPresent = (mode != 3);
      ps = 2'($random(seed));
      rs = 3'($random(seed));
      @(negedge clk);
      if (useExt) extRstN = 1'b0;
      else sys_rst = 1'b1;
      strapPortSel = ps;
      strapRemoveSel = rs;
      repeat (12) @(negedge clk);
      cmpVal(16'(cfgReady), 16'h0000);
      sys_rst = 1'b0;
      extRstN = 1'b1;
      // Straps move after reset; the latched choice must hold.
      strapPortSel = ~ps;
      strapRemoveSel = ~rs;
      n = 0;
      while (cfgReady !== 1'b1 && n < 20000) begin
         @(negedge clk);
         n++;
      end
      cmpVal(16'(cfgReady), 16'h0001);
      ok = (mode == 0);
      cmpVal(16'(romValid), 16'(ok));
      if (ok) begin
         cmpVal(vendorId, {eep.mem[3], eep.mem[2]});
         cmpVal(productId, {eep.mem[5], eep.mem[4]});
         cmpVal(releaseBcd, {eep.mem[7], eep.mem[6]});
         cmpVal(16'(portCount), 16'(eep.mem[26][3:0]));
         cmpVal(16'(removableMask), 16'(eep.mem[28]));
         cmpVal(16'(serialLen), (eep.mem[24] > 16) ? 16'd16 : 16'(eep.mem[24]));
         cmpVal(16'(deviceAttr), 16'(eep.mem[30]));
      end else begin
         cmpVal(vendorId, hub_cfg_pkg::DEF_VID);
         cmpVal(productId, hub_cfg_pkg::DEF_PID);
         cmpVal(releaseBcd, hub_cfg_pkg::DEF_REL);
         cmpVal(16'(portCount), 16'(4 + int'(ps)));
         cmpVal(16'(removableMask), 16'(((1 << (rs + 1)) - 1) & 'hfe));
      end
      powerAndSuspend();
      $display("load mode %0d finished", mode);
   endtask

   // ----------------------------------------
   // Main sequence, alternating the two reset sources
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      extRstN = 1'b1;
      hubConfigured = 1'b0;
      suspendReq = 1'b0;
      romPresent = 1'b1;
      overcurrentN = 7'h7f;
      strapPortSel = 2'h0;
      strapRemoveSel = 3'h0;
      runLoad(1'b0, 0);
      runLoad(1'b1, 2);
      runLoad(1'b0, 1);
      runLoad(1'b1, 3);
      print_verdict();
   end
endmodule // tb
